// ==== design/dcc_pkg.sv ====
/*
  Shared constants and types for the dual comparator control block:
  register offsets, field positions, reset values and timing counts.
  Assumes a single 200 MHz clock and an 9-bit register address space.
*/
`default_nettype none

package dcc_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CMP_ONE_CTRL = 9'h119;
  localparam logic [ADDR_W-1:0] OFS_CMP_TWO_CTRL = 9'h11a;
  localparam logic [ADDR_W-1:0] OFS_CMP_TWO_SYNC = 9'h11b;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 9'h11c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 9'h11d;

  // control register field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_PIN_DRIVE = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_REF_SELECT = 2;
  localparam int BIT_CH_HI = 1;
  localparam int BIT_CH_LO = 0;

  // sync and mirror register field positions
  localparam int BIT_MIRROR_A = 7;
  localparam int BIT_MIRROR_B = 6;
  localparam int BIT_GATE_SOURCE = 1;
  localparam int BIT_SYNC_ENABLE = 0;

  // interrupt status and mask field positions
  localparam int BIT_IRQ_A = 0;
  localparam int BIT_IRQ_B = 1;

  localparam logic GATE_SOURCE_RST = 1'b1;
  localparam logic SYNC_ENABLE_RST = 1'b0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

  // instruction cycle: four clocks of the core clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int INSTR_CYCLE_NS = 20;
  localparam int INSTR_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);
  localparam logic [1:0] INSTR_ZERO = 2'h0;

  typedef enum logic [1:0] {
    DCC_CH_PIN1 = 2'b00,
    DCC_CH_PIN5 = 2'b01,
    DCC_CH_PIN6 = 2'b10,
    DCC_CH_PIN7 = 2'b11
  } dcc_chan_e;

  typedef struct packed {
    logic enable;
    logic pin_drive;
    logic invert;
    logic ref_select;
    dcc_chan_e channel;
  } dcc_ctrl_s;

  localparam dcc_ctrl_s CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, DCC_CH_PIN1};

  typedef struct packed {
    logic out;
    logic oe;
  } dcc_pin_s;

endpackage

`default_nettype wire

// ==== design/dcc_top.sv ====
/*
  Dual comparator control: enables, input steering, polarity, the
  cycle-latched result bits, pin drive, mirror register, timer gate
  source with optional sync of comparator b to the timer clock, and a
  change interrupt. Assumes the analog front end delivers each raw
  comparison as an asynchronous bit, and that the timer clock arrives
  after its prescaler as a plain pin sampled on CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module dcc_sync3 (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic stable_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      stable_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a change counts only once two late stages agree
      if (s2_r == s3_r)
      begin
        stable_r <= s3_r;
      end
    end
  end

  assign dout = stable_r;
endmodule

module dcc_top (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [dcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [dcc_pkg::DATA_W-1:0] RDATA,
  input wire logic CMP_A_RAW,
  input wire logic CMP_B_RAW,
  input wire logic TIMER_CLK_PRESCALED,
  input wire logic TIMER_GATE_PIN,
  input wire logic PORT_DIR_A,
  input wire logic PORT_DIR_B,
  output logic CMP_A_POWER,
  output logic CMP_B_POWER,
  output logic CMP_A_REF_SELECT,
  output logic CMP_B_REF_SELECT,
  output logic [1:0] CMP_A_CHANNEL,
  output logic [1:0] CMP_B_CHANNEL,
  output logic CMP_A_PIN_OUT,
  output logic CMP_A_PIN_OE,
  output logic CMP_B_PIN_OUT,
  output logic CMP_B_PIN_OE,
  output logic TIMER_GATE,
  output logic IRQ
);
  import dcc_pkg::*;

  dcc_ctrl_s ctrl_a_r;
  dcc_ctrl_s ctrl_b_r;
  logic gate_source_r;
  logic sync_enable_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] instr_cnt_r;
  logic lat_a_r;
  logic lat_b_r;
  logic prev_a_r;
  logic prev_b_r;
  logic tclk_prev_r;
  logic b_synced_r;
  logic gate_r;
  logic irq_r;
  dcc_pin_s pin_a_r;
  dcc_pin_s pin_b_r;

  logic raw_a;
  logic raw_b;
  logic tclk;
  logic gate_pin;

  dcc_sync3 u_sync_a (
    .clk(CLK),
    .srst(SRST),
    .din(CMP_A_RAW),
    .dout(raw_a)
  );
  dcc_sync3 u_sync_b (
    .clk(CLK),
    .srst(SRST),
    .din(CMP_B_RAW),
    .dout(raw_b)
  );
  // timer clock is taken after its prescaler
  dcc_sync3 u_sync_tclk (
    .clk(CLK),
    .srst(SRST),
    .din(TIMER_CLK_PRESCALED),
    .dout(tclk)
  );
  dcc_sync3 u_sync_gate (
    .clk(CLK),
    .srst(SRST),
    .din(TIMER_GATE_PIN),
    .dout(gate_pin)
  );

  // live results: disabled comparator reads low, then polarity
  wire live_a = ctrl_a_r.enable & raw_a;
  wire live_b = ctrl_b_r.enable & raw_b;
  wire res_a = live_a ^ ctrl_a_r.invert;
  wire res_b = live_b ^ ctrl_b_r.invert;

  // bus decode
  wire sel_one = (ADDR == OFS_CMP_ONE_CTRL);
  wire sel_two = (ADDR == OFS_CMP_TWO_CTRL);
  wire sel_sync = (ADDR == OFS_CMP_TWO_SYNC);
  wire sel_stat = (ADDR == OFS_IRQ_STATUS);
  wire sel_mask = (ADDR == OFS_IRQ_MASK);

  wire dcc_ctrl_s wr_ctrl = '{WDATA[BIT_ENABLE], WDATA[BIT_PIN_DRIVE],
    WDATA[BIT_INVERT], WDATA[BIT_REF_SELECT],
    dcc_chan_e'(WDATA[BIT_CH_HI:BIT_CH_LO])};

  // read views; holes stay zero
  wire [DATA_W-1:0] rd_one = {ctrl_a_r.enable, lat_a_r,
    ctrl_a_r.pin_drive, ctrl_a_r.invert, 1'b0, ctrl_a_r.ref_select,
    ctrl_a_r.channel};
  wire [DATA_W-1:0] rd_two = {ctrl_b_r.enable, lat_b_r,
    ctrl_b_r.pin_drive, ctrl_b_r.invert, 1'b0, ctrl_b_r.ref_select,
    ctrl_b_r.channel};
  // both mirrors come from one register set in one read
  wire [DATA_W-1:0] rd_sync = {lat_a_r, lat_b_r, 4'h0, gate_source_r,
    sync_enable_r};
  wire [DATA_W-1:0] rd_stat = {6'h00, irq_status_r};
  wire [DATA_W-1:0] rd_mask = {6'h00, irq_mask_r};
  wire [DATA_W-1:0] rd_mux = sel_one ? rd_one :
    sel_two ? rd_two :
    sel_sync ? rd_sync :
    sel_stat ? rd_stat :
    sel_mask ? rd_mask : RDATA_IDLE;

  // instruction cycle boundary
  wire instr_end = (instr_cnt_r == INSTR_LAST);

  // edges of the latched result; reads play no part in this
  wire chg_a = lat_a_r ^ prev_a_r;
  wire chg_b = lat_b_r ^ prev_b_r;
  wire [1:0] irq_evt = {chg_b, chg_a};
  wire wr_stat = WE & sel_stat;
  wire [1:0] irq_clr = wr_stat ? WDATA[BIT_IRQ_B:BIT_IRQ_A] : IRQ_RST;
  // a change in the clearing cycle still lands
  wire [1:0] irq_nxt = (irq_status_r & ~irq_clr) | irq_evt;

  // falling edge of the timer clock; the timer counts on rising
  wire tclk_fall = tclk_prev_r & ~tclk;
  // without sync b reaches the gate as it changes
  wire b_timer = sync_enable_r ? b_synced_r : res_b;

  wire dir_out_a = ~PORT_DIR_A;
  wire dir_out_b = ~PORT_DIR_B;

  // one write strobe per register keeps each process small
  wire wr_one = WE & sel_one;
  wire wr_two = WE & sel_two;
  wire wr_sync = WE & sel_sync;
  wire wr_mask = WE & sel_mask;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ctrl_a_r <= CTRL_RST;
    end
    else if (wr_one)
    begin
      ctrl_a_r <= wr_ctrl;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ctrl_b_r <= CTRL_RST;
    end
    else if (wr_two)
    begin
      ctrl_b_r <= wr_ctrl;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      gate_source_r <= GATE_SOURCE_RST;
      sync_enable_r <= SYNC_ENABLE_RST;
    end
    else if (wr_sync)
    begin
      gate_source_r <= WDATA[BIT_GATE_SOURCE];
      sync_enable_r <= WDATA[BIT_SYNC_ENABLE];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      irq_mask_r <= IRQ_RST;
    end
    else if (wr_mask)
    begin
      irq_mask_r <= WDATA[BIT_IRQ_B:BIT_IRQ_A];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rdata_r <= RDATA_IDLE;
    end
    else
    begin
      // data stand for one cycle after each cycle with RE high, then idle
      rdata_r <= RE ? rd_mux : RDATA_IDLE;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      irq_status_r <= IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_status_r <= irq_nxt;
      // level follows the masked status; it stays up until ones are written to the status or the mask bits are cleared
      irq_r <= |(irq_nxt & irq_mask_r);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      instr_cnt_r <= INSTR_ZERO;
    end
    else
    begin
      // free running; software sees results at these ticks only
      instr_cnt_r <= instr_end ? INSTR_ZERO : instr_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      lat_a_r <= 1'b0;
      lat_b_r <= 1'b0;
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
    end
    else
    begin
      if (instr_end)
      begin
        lat_a_r <= res_a;
        lat_b_r <= res_b;
      end
      prev_a_r <= lat_a_r;
      prev_b_r <= lat_b_r;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      tclk_prev_r <= 1'b0;
      b_synced_r <= 1'b0;
      gate_r <= GATE_SOURCE_RST;
    end
    else
    begin
      tclk_prev_r <= tclk;
      if (tclk_fall)
      begin
        b_synced_r <= res_b;
      end
      gate_r <= gate_source_r ? gate_pin : b_timer;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_a_r <= '0;
      pin_b_r <= '0;
    end
    else
    begin
      // pins follow the unlatched result
      pin_a_r.out <= res_a;
      pin_b_r.out <= res_b;
      pin_a_r.oe <= ctrl_a_r.pin_drive & ctrl_a_r.enable
        & dir_out_a;
      pin_b_r.oe <= ctrl_b_r.pin_drive & ctrl_b_r.enable
        & dir_out_b;
    end
  end

  assign RDATA = rdata_r;
  assign CMP_A_POWER = ctrl_a_r.enable;
  assign CMP_B_POWER = ctrl_b_r.enable;
  assign CMP_A_REF_SELECT = ctrl_a_r.ref_select;
  assign CMP_B_REF_SELECT = ctrl_b_r.ref_select;
  assign CMP_A_CHANNEL = ctrl_a_r.channel;
  assign CMP_B_CHANNEL = ctrl_b_r.channel;
  assign CMP_A_PIN_OUT = pin_a_r.out;
  assign CMP_A_PIN_OE = pin_a_r.oe;
  assign CMP_B_PIN_OUT = pin_b_r.out;
  assign CMP_B_PIN_OE = pin_b_r.oe;
  assign TIMER_GATE = gate_r;
  assign IRQ = irq_r;
endmodule

`default_nettype wire

// ==== tb/dcc_far_side.sv ====
/*
  Far side model: comparison levels, gate pin and prescaled timer clock.
  Assumes the bench sets the levels and asks for timer ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_far_side (
  input wire logic clk,
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire logic gate_lvl,
  input wire logic tick,
  output logic raw_a,
  output logic raw_b,
  output logic gate,
  output var logic tclk
);
  initial tclk = 1'b1;
  // analog edges land off the clock edge
  assign #2 raw_a = a_lvl;
  assign #2 raw_b = b_lvl;
  assign #2 gate = gate_lvl;
  // timer clock idles high; a tick gives one slow fall and rise
  always @(posedge clk)
  begin
    if (tick)
    begin
      #1 tclk = 1'b0;
      repeat (6) @(posedge clk);
      #1 tclk = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dcc_top_asserts.sv ====
/*
  Checker for the comparator control block: control outputs, pin drive
  and register read-back. Bound to dcc_top; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_chk (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [dcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  input wire logic [dcc_pkg::DATA_W-1:0] RDATA,
  input wire logic PORT_DIR_A,
  input wire logic PORT_DIR_B,
  input wire logic CMP_A_POWER,
  input wire logic CMP_B_POWER,
  input wire logic CMP_A_REF_SELECT,
  input wire logic CMP_B_REF_SELECT,
  input wire logic [1:0] CMP_A_CHANNEL,
  input wire logic [1:0] CMP_B_CHANNEL,
  input wire logic CMP_A_PIN_OE,
  input wire logic CMP_B_PIN_OE
);
  import dcc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_wr_a; WE && ADDR == OFS_CMP_ONE_CTRL; endsequence
  sequence s_wr_b; WE && ADDR == OFS_CMP_TWO_CTRL; endsequence
  sequence s_rd_sync; RE && ADDR == OFS_CMP_TWO_SYNC; endsequence
  AST_POWER_A: assert property (
    s_wr_a |=> CMP_A_POWER == $past(WDATA[BIT_ENABLE])) else $error("power");
  AST_POWER_B: assert property (
    s_wr_b |=> CMP_B_POWER == $past(WDATA[BIT_ENABLE]))
    else $error("power b");
  AST_REF_A: assert property (
    s_wr_a |=> CMP_A_REF_SELECT == $past(WDATA[BIT_REF_SELECT]))
    else $error("ref sel a");
  AST_REF_B: assert property (
    s_wr_b |=> CMP_B_REF_SELECT == $past(WDATA[BIT_REF_SELECT]))
    else $error("ref sel");
  AST_CHAN_A: assert property (
    s_wr_a |=> CMP_A_CHANNEL == $past(WDATA[BIT_CH_HI:BIT_CH_LO]))
    else $error("channel a");
  AST_CHAN_B: assert property (
    s_wr_b |=> CMP_B_CHANNEL == $past(WDATA[BIT_CH_HI:BIT_CH_LO]))
    else $error("channel");
  AST_OE_A: assert property (
    CMP_A_PIN_OE |-> $past(CMP_A_POWER) && !$past(PORT_DIR_A))
    else $error("pin drive");
  AST_OE_B: assert property (
    CMP_B_PIN_OE |-> $past(CMP_B_POWER) && !$past(PORT_DIR_B))
    else $error("pin drive b");
  AST_HOLE_CTRL: assert property (
    RE && (ADDR == OFS_CMP_ONE_CTRL || ADDR == OFS_CMP_TWO_CTRL) |=> !RDATA[3])
    else $error("ctrl hole");
  AST_HOLE_SYNC: assert property (
    s_rd_sync |-> ##1 RDATA[5:2] == 4'h0) else $error("sync hole");
  AST_RD_IDLE: assert property (
    !$past(RE) |-> RDATA == RDATA_IDLE) else $error("read idle");
  AST_UNMAPPED: assert property (
    RE && ADDR > OFS_IRQ_MASK |=> RDATA == 8'h00) else $error("unmapped");
endmodule
bind dcc_top dcc_chk u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR),
  .WDATA(WDATA), .WE(WE), .RE(RE), .RDATA(RDATA), .PORT_DIR_A(PORT_DIR_A),
  .PORT_DIR_B(PORT_DIR_B), .CMP_A_POWER(CMP_A_POWER),
  .CMP_B_POWER(CMP_B_POWER), .CMP_A_REF_SELECT(CMP_A_REF_SELECT),
  .CMP_B_REF_SELECT(CMP_B_REF_SELECT), .CMP_A_CHANNEL(CMP_A_CHANNEL),
  .CMP_B_CHANNEL(CMP_B_CHANNEL), .CMP_A_PIN_OE(CMP_A_PIN_OE),
  .CMP_B_PIN_OE(CMP_B_PIN_OE));
`default_nettype wire

// ==== tb/dcc_top_tb_top.sv ====
/*
  Testbench for dcc_top: register table loop, reset values, comparator,
  interrupt, pin drive and timer gate cases. Assumes dcc_far_side.
*/
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb_top;
  import dcc_pkg::*;
  typedef struct {logic [8:0] a; logic [7:0] w; logic [7:0] e;} dcc_row_s;
  dcc_row_s rows [6] = '{'{OFS_CMP_ONE_CTRL, 8'h2c, 8'h24},
    '{OFS_CMP_ONE_CTRL, 8'h61, 8'h21}, '{OFS_CMP_TWO_CTRL, 8'h0e, 8'h06},
    '{OFS_CMP_TWO_SYNC, 8'hfc, 8'h00}, '{OFS_IRQ_MASK, 8'h03, 8'h03},
    '{9'h11e, 8'hff, 8'h00}};
  logic clk = 0, srst = 1, we = 0, re = 0, tick = 0;
  logic [8:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic a_lvl = 1, b_lvl = 1, gate_lvl = 0, dir_a = 1, dir_b = 0;
  logic raw_a, raw_b, gate, tclk, oe_a, pout_a, tgate, irq;
  logic oe_b, pout_b;
  int errors = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  dcc_top dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WE(we),
    .RE(re), .RDATA(rdata), .CMP_A_RAW(raw_a), .CMP_B_RAW(raw_b),
    .TIMER_CLK_PRESCALED(tclk), .TIMER_GATE_PIN(gate), .PORT_DIR_A(dir_a),
    .PORT_DIR_B(dir_b), .CMP_A_POWER(), .CMP_B_POWER(), .CMP_A_REF_SELECT(),
    .CMP_B_REF_SELECT(), .CMP_A_CHANNEL(), .CMP_B_CHANNEL(),
    .CMP_A_PIN_OUT(pout_a), .CMP_A_PIN_OE(oe_a), .CMP_B_PIN_OUT(pout_b),
    .CMP_B_PIN_OE(oe_b), .TIMER_GATE(tgate), .IRQ(irq));
  dcc_far_side far (.clk(clk), .a_lvl(a_lvl), .b_lvl(b_lvl),
    .gate_lvl(gate_lvl), .tick(tick), .raw_a(raw_a), .raw_b(raw_b),
    .gate(gate), .tclk(tclk));
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // bounded wait on irq (0), pin enable (1) or timer gate (2)
  task automatic await(input int k, input logic v);
    logic s;
    for (int i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1 s = (k == 0) ? irq : (k == 1) ? oe_a : tgate;
      if (s === v)
        break;
    end
    chk({7'h0, s}, {7'h0, v});
    if (s !== v)
      report_and_stop();
  endtask
  task automatic pulse();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_CMP_ONE_CTRL, 8'h00);
    rd(OFS_CMP_TWO_SYNC, 8'h02);
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_CMP_ONE_CTRL, 8'h80);
    await(0, 1'b1);
    rd(OFS_CMP_ONE_CTRL, 8'hc0);
    rd(OFS_CMP_TWO_SYNC, 8'h82);
    rd(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_STATUS, 8'h01);
    await(0, 1'b0);
    wr(OFS_CMP_ONE_CTRL, 8'h90);
    await(0, 1'b1);
    rd(OFS_CMP_ONE_CTRL, 8'h90);
    wr(OFS_IRQ_MASK, 8'h00);
    await(0, 1'b0);
    @(posedge clk);
    dir_a <= 1'b0;
    wr(OFS_CMP_ONE_CTRL, 8'ha0);
    await(1, 1'b1);
    chk({7'h0, pout_a}, 8'h01);
    @(posedge clk);
    dir_a <= 1'b1;
    await(1, 1'b0);
    wr(OFS_CMP_TWO_SYNC, 8'h02);
    gate_lvl <= 1'b1;
    await(2, 1'b1);
    wr(OFS_CMP_TWO_SYNC, 8'h01);
    pulse();
    // let the capture of the disabled result land first
    repeat (10) @(posedge clk);
    wr(OFS_CMP_TWO_CTRL, 8'ha0);
    repeat (20) @(posedge clk);
    #1 chk({7'h0, tgate}, 8'h00);
    chk({6'h0, oe_b, pout_b}, 8'h03);
    rd(OFS_IRQ_STATUS, 8'h03);
    rd(OFS_CMP_TWO_SYNC, 8'hc1);
    pulse();
    await(2, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
